//--- inc/litu_defines.vh
// ----------------------------------------------------------------
// Overview of operation
// - Extended mode: model access to a reserved address faults.
// - Extended mode: non-zero write to error flags faults.
// - Fixed, start-up or legacy-mode lowest command, or extended-mode self write, with vector 0fh or below flags send error while error entry unmasked.
// - Received interrupt with vector 0fh or below flags receive error while error entry unmasked.
// - Illegal received vector is not offered nor logged.
// - Extended mode lowest-priority command is not sent, and flags redirect while error entry unmasked.
// - Extended mode lowest priority plus illegal vector sets only the redirect flag while error entry unmasked.
// - 32-bit down-counter with divide, initial, current, vector entry.
// - Timer decrements at clock rate over the selected divisor.
// - One-shot: initial write loads current count and starts.
// - One-shot: one interrupt at zero, count holds at 0.
// - Periodic: interrupt at zero, reload from initial, continue.
// - Initial write during countdown restarts from the new value.
// - Timer interrupt uses entry vector, suppressed while masked.
// - Accepted offers logged as pending; refused ones are retried.
// - Only a low-word command write launches the interrupt.
// - Command fields read-write except read-only delivery status.
// - Delivery type codes 000 to 110 decoded as documented.
// - Restart de-assert goes to all units, all-including-self.
// - Start-up interrupts are not retried after failed delivery.
// - Destination mode bit: 0 physical, 1 logical.
// - Delivery status is 1 from send until accepted or a start-up send fails, else 0.
// - Timer mode bit: 0 one-shot, 1 periodic.
// - Any error flag set raises error interrupt via error entry.
// - Two-bit shorthand: none, self, all, all but self.
// ----------------------------------------------------------------
`ifndef LITU_DEFINES_VH
`define LITU_DEFINES_VH
// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define LITU_A_ERR   8'h28
`define LITU_A_ICRL  8'h30
`define LITU_A_ICRH  8'h31
`define LITU_A_TVEC  8'h32
`define LITU_A_EVEC  8'h37
`define LITU_A_ICNT  8'h38
`define LITU_A_CCNT  8'h39
`define LITU_A_DIV   8'h3e
`define LITU_A_SELF  8'h3f
// ----------------------------------------------------------------
// Fields and values
// ----------------------------------------------------------------
`define LITU_MASK_BIT  16
`define LITU_TMODE_BIT 17
`define LITU_E_REDIR   4
`define LITU_E_SILL    5
`define LITU_E_RILL    6
`define LITU_C_DMODE   11
`define LITU_C_STAT    12
`define LITU_C_LEVEL   14
`define LITU_C_TRIG    15
`define LITU_DT_FIXED  3'h0
`define LITU_DT_LOWEST 3'h1
`define LITU_DT_SMI    3'h2
`define LITU_DT_RSVD   3'h3
`define LITU_DT_NMI    3'h4
`define LITU_DT_INIT   3'h5
`define LITU_DT_START  3'h6
`define LITU_SH_ALL    2'h2
`define LITU_VEC_MAX   8'h0f
`define LITU_ENTRY_RST 18'h10000
`endif

//--- rtl/litu_top.v
`include "litu_defines.vh"
`default_nettype none
module litu_top #(
  parameter DIV_W = 3
) (
  input  wire         clock,
  input  wire         reset,
  input  wire         ext_mode,
  input  wire         mreg_rd,
  input  wire         mreg_wr,
  input  wire [7:0]   mreg_addr,
  input  wire [31:0]  mreg_wdata,
  output reg  [31:0]  mreg_rdata,
  output reg          mreg_fault,
  input  wire         rx_valid,
  input  wire [7:0]   rx_vector,
  output wire         rx_ready,
  output reg          core_offer_valid,
  output reg  [7:0]   core_offer_vector,
  input  wire         core_accept,
  input  wire         core_refuse,
  input  wire         core_eoi_valid,
  input  wire [7:0]   core_eoi_vector,
  output reg  [255:0] pending_request,
  output reg          tx_valid,
  output reg  [7:0]   tx_vector,
  output reg  [2:0]   tx_type,
  output reg          tx_dest_mode,
  output reg          tx_level,
  output reg          tx_trigger,
  output reg  [1:0]   tx_shorthand,
  output reg  [7:0]   tx_dest,
  input  wire         tx_accept,
  input  wire         tx_fail
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg  [6:0]       err_reg;
  reg  [17:0]      tvec_reg;
  reg  [17:0]      evec_reg;
  reg  [31:0]      icnt_reg;
  reg  [31:0]      cur_reg;
  reg  [DIV_W-1:0] div_reg;
  reg  [6:0]       pre_reg;
  reg  [19:0]      icrl_reg;
  reg  [7:0]       icrh_reg;
  reg              rx_pend_reg;
  reg  [7:0]       rx_vec_reg;
  reg              tmr_pend_reg;
  reg              err_pend_reg;
  reg  [1:0]       offer_src_reg;

  localparam [1:0] SRC_RX  = 2'h0;
  localparam [1:0] SRC_TMR = 2'h1;
  localparam [1:0] SRC_ERR = 2'h2;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire wr_err  = mreg_wr && mreg_addr == `LITU_A_ERR;
  wire wr_icrl = mreg_wr && mreg_addr == `LITU_A_ICRL;
  wire wr_icrh = mreg_wr && mreg_addr == `LITU_A_ICRH;
  wire wr_icnt = mreg_wr && mreg_addr == `LITU_A_ICNT;
  wire wr_self = mreg_wr && ext_mode && mreg_addr == `LITU_A_SELF;
  wire wr_tvec = mreg_wr && mreg_addr == `LITU_A_TVEC;
  wire wr_evec = mreg_wr && mreg_addr == `LITU_A_EVEC;
  wire wr_div  = mreg_wr && mreg_addr == `LITU_A_DIV;
  reg  known;
  always @* begin
    if (mreg_addr == `LITU_A_ERR)
      known = 1'b1;
    else if (mreg_addr == `LITU_A_ICRL || mreg_addr == `LITU_A_ICRH)
      known = 1'b1;
    else if (mreg_addr == `LITU_A_TVEC || mreg_addr == `LITU_A_EVEC)
      known = 1'b1;
    else if (mreg_addr == `LITU_A_ICNT || mreg_addr == `LITU_A_CCNT)
      known = 1'b1;
    else if (mreg_addr == `LITU_A_DIV || mreg_addr == `LITU_A_SELF)
      known = 1'b1;
    else
      known = 1'b0;
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire [7:0] w_vec   = mreg_wdata[7:0];
  wire [2:0] w_type  = mreg_wdata[10:8];
  wire       w_ill   = w_vec <= `LITU_VEC_MAX;
  // Vector-carrying types only; other sent types carry the written vector unchecked
  wire       w_uses_vec = w_type == `LITU_DT_FIXED ||
                          w_type == `LITU_DT_LOWEST ||
                          w_type == `LITU_DT_START;
  wire       w_redir = ext_mode && w_type == `LITU_DT_LOWEST;
  wire       w_sill  = (wr_icrl && w_uses_vec && !w_redir && w_ill) ||
                       (wr_self && w_ill);
  wire       w_send  = wr_icrl && !w_redir && !w_sill &&
                       w_type != `LITU_DT_RSVD;
  // Restart de-assert: level 0, trigger 1, goes everywhere
  wire       w_deassert = w_type == `LITU_DT_INIT &&
                          !mreg_wdata[`LITU_C_LEVEL] &&
                          mreg_wdata[`LITU_C_TRIG];

  // ----------------------------------------------------------------
  // Timer
  // ----------------------------------------------------------------
  wire [6:0] div_mask = (7'h01 << div_reg) - 7'h01;
  wire       tick     = pre_reg == div_mask;
  wire       t_zero   = tick && cur_reg == 32'h1 && !wr_icnt;
  wire       t_ill    = tvec_reg[7:0] <= `LITU_VEC_MAX;
  wire       t_evt    = t_zero && !tvec_reg[`LITU_MASK_BIT];

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      pre_reg <= 7'h00;
      cur_reg <= 32'h0;
    end else if (wr_icnt) begin
      // Restarting the prescaler gives the new count a whole first period
      pre_reg <= 7'h00;
      cur_reg <= mreg_wdata;
    end else begin
      pre_reg <= tick ? 7'h00 : pre_reg + 7'h01;
      if (tick && cur_reg != 32'h0) begin
        if (cur_reg == 32'h1 && tvec_reg[`LITU_TMODE_BIT])
          cur_reg <= icnt_reg;
        else
          cur_reg <= cur_reg - 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Error flags
  // ----------------------------------------------------------------
  wire       rx_ill = rx_valid && rx_ready && rx_vector <= `LITU_VEC_MAX;
  wire [6:0] err_set = {rx_ill || (t_evt && t_ill),
                        w_sill, wr_icrl && w_redir, 4'h0};
  // Masked error entry keeps the flags from being recorded
  wire       err_rec = !evec_reg[`LITU_MASK_BIT];
  wire       err_evt = err_rec && |err_set;

  always @(posedge clock or posedge reset) begin
    if (reset)
      err_reg <= 7'h00;
    else if (wr_err && !(ext_mode && mreg_wdata != 32'h0))
      err_reg <= err_rec ? err_set : 7'h00;
    else if (err_rec)
      err_reg <= err_reg | err_set; // Set wins over clear
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      tvec_reg <= `LITU_ENTRY_RST;
      evec_reg <= `LITU_ENTRY_RST;
      icnt_reg <= 32'h0;
      div_reg  <= {DIV_W{1'b0}};
      icrl_reg <= 20'h0;
      icrh_reg <= 8'h00;
    end else if (mreg_wr) begin
      if (wr_tvec)
        tvec_reg <= mreg_wdata[17:0];
      // Error entry has no mode bit, so bit 17 stays zero
      else if (wr_evec)
        evec_reg <= {1'b0, mreg_wdata[16:0]};
      else if (wr_icnt)
        icnt_reg <= mreg_wdata;
      else if (wr_div)
        div_reg <= mreg_wdata[DIV_W-1:0];
      else if (wr_icrl)
        icrl_reg <= mreg_wdata[19:0];
      else if (wr_icrh)
        icrh_reg <= mreg_wdata[31:24];
    end
  end

  // ----------------------------------------------------------------
  // Outgoing interrupt
  // ----------------------------------------------------------------
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      tx_valid     <= 1'b0;
      tx_vector    <= 8'h00;
      tx_type      <= 3'h0;
      tx_dest_mode <= 1'b0;
      tx_level     <= 1'b0;
      tx_trigger   <= 1'b0;
      tx_shorthand <= 2'h0;
      tx_dest      <= 8'h00;
    end else if (w_send) begin
      tx_valid     <= 1'b1;
      tx_vector    <= w_vec;
      tx_type      <= w_type;
      tx_dest_mode <= mreg_wdata[`LITU_C_DMODE];
      tx_level     <= mreg_wdata[`LITU_C_LEVEL];
      tx_trigger   <= mreg_wdata[`LITU_C_TRIG];
      tx_shorthand <= w_deassert ? `LITU_SH_ALL
                                 : mreg_wdata[19:18];
      tx_dest      <= icrh_reg;
    end else if (tx_valid) begin
      if (tx_accept)
        tx_valid <= 1'b0;
      else if (tx_fail && tx_type == `LITU_DT_START)
        tx_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Local sources
  // ----------------------------------------------------------------
  // One receive slot; the far end waits on rx_ready
  assign rx_ready = !rx_pend_reg;

  wire take    = core_offer_valid && core_accept;
  wire back    = core_offer_valid && core_refuse;
  wire self_ok = wr_self && !w_ill;

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_pend_reg  <= 1'b0;
      rx_vec_reg   <= 8'h00;
      tmr_pend_reg <= 1'b0;
      err_pend_reg <= 1'b0;
    end else begin
      if (take && offer_src_reg == SRC_RX)
        rx_pend_reg <= 1'b0;
      if (take && offer_src_reg == SRC_TMR)
        tmr_pend_reg <= 1'b0;
      if (take && offer_src_reg == SRC_ERR)
        err_pend_reg <= 1'b0;
      if (rx_valid && rx_ready && !rx_ill) begin
        rx_pend_reg <= 1'b1;
        rx_vec_reg  <= rx_vector;
      end else if (self_ok && !rx_pend_reg) begin
        rx_pend_reg <= 1'b1;
        rx_vec_reg  <= w_vec;
      end
      if (t_evt && !t_ill)
        tmr_pend_reg <= 1'b1;
      if (err_evt)
        err_pend_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Offer to the core
  // ----------------------------------------------------------------
  // A refused offer drops back; its source stays pending and is
  // offered again, so nothing is lost at the cost of a retry gap
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      core_offer_valid  <= 1'b0;
      core_offer_vector <= 8'h00;
      offer_src_reg     <= 2'h0;
    end else if (core_offer_valid) begin
      if (take || back)
        core_offer_valid <= 1'b0;
    end else if (rx_pend_reg) begin
      core_offer_valid  <= 1'b1;
      core_offer_vector <= rx_vec_reg;
      offer_src_reg     <= SRC_RX;
    end else if (tmr_pend_reg) begin
      core_offer_valid  <= 1'b1;
      core_offer_vector <= tvec_reg[7:0];
      offer_src_reg     <= SRC_TMR;
    end else if (err_pend_reg) begin
      core_offer_valid  <= 1'b1;
      core_offer_vector <= evec_reg[7:0];
      offer_src_reg     <= SRC_ERR;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset)
      pending_request <= 256'h0;
    else begin
      if (core_eoi_valid)
        pending_request[core_eoi_vector] <= 1'b0;
      if (take)
        pending_request[core_offer_vector] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Protection fault
  // ----------------------------------------------------------------
  // Legacy mode never faults; unknown indices there just read zero
  reg        fault_next;
  always @* begin
    fault_next = 1'b0;
    if (!ext_mode)
      fault_next = 1'b0;
    else if (!mreg_rd && !mreg_wr)
      fault_next = 1'b0;
    else if (!known)
      fault_next = 1'b1;
    else if (wr_err && mreg_wdata != 32'h0)
      fault_next = 1'b1;
  end

  // ----------------------------------------------------------------
  // Read and fault
  // ----------------------------------------------------------------
  reg [31:0] rdata_next;
  always @* begin
    rdata_next = mreg_rdata;
    if (!mreg_rd)
      rdata_next = mreg_rdata;
    else if (mreg_addr == `LITU_A_ERR)
      rdata_next = {25'h0, err_reg};
    else if (mreg_addr == `LITU_A_ICRL)
      rdata_next = {12'h0, icrl_reg[19:13], tx_valid,
                    icrl_reg[11:0]};
    else if (mreg_addr == `LITU_A_ICRH)
      rdata_next = {icrh_reg, 24'h0};
    else if (mreg_addr == `LITU_A_TVEC)
      rdata_next = {14'h0, tvec_reg};
    else if (mreg_addr == `LITU_A_EVEC)
      rdata_next = {14'h0, evec_reg};
    else if (mreg_addr == `LITU_A_ICNT)
      rdata_next = icnt_reg;
    else if (mreg_addr == `LITU_A_CCNT)
      rdata_next = cur_reg;
    else if (mreg_addr == `LITU_A_DIV)
      rdata_next = {{(32-DIV_W){1'b0}}, div_reg};
    else
      rdata_next = 32'h0;
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      mreg_rdata <= 32'h0;
      mreg_fault <= 1'b0;
    end else begin
      mreg_fault <= fault_next;
      mreg_rdata <= rdata_next;
    end
  end

endmodule // litu_top
`default_nettype wire

//--- verification/litu_chk.sv
`include "litu_defines.vh"
`default_nettype none
module litu_chk (
  input wire logic         clock,
  input wire logic         reset,
  input wire logic         ext_mode,
  input wire logic         mreg_rd,
  input wire logic         mreg_wr,
  input wire logic [7:0]   mreg_addr,
  input wire logic [31:0]  mreg_wdata,
  input wire logic         mreg_fault,
  input wire logic         core_offer_valid,
  input wire logic [7:0]   core_offer_vector,
  input wire logic         core_accept,
  input wire logic         core_refuse,
  input wire logic [255:0] pending_request,
  input wire logic         tx_valid,
  input wire logic [7:0]   tx_vector,
  input wire logic [2:0]   tx_type,
  input wire logic         tx_level,
  input wire logic         tx_trigger,
  input wire logic [1:0]   tx_shorthand,
  input wire logic         tx_accept,
  input wire logic         tx_fail
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // Checks
  // ----
  wire       low_wr  = mreg_wr && mreg_addr == `LITU_A_ICRL;
  wire [7:0] wvec    = mreg_wdata[7:0];
  wire [2:0] wtype   = mreg_wdata[10:8];
  wire       req_ext = ext_mode && (mreg_rd || mreg_wr);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_fault_cause: assert property (mreg_fault |-> $past(req_ext))
    else $error("fault without extended access");
  a_err_fault: assert property (ext_mode && mreg_wr &&
    mreg_addr == `LITU_A_ERR && mreg_wdata != 0 |=> mreg_fault)
    else $error("no fault on non-zero error write");
  a_high_quiet: assert property (!tx_valid && mreg_wr &&
    mreg_addr == `LITU_A_ICRH |=> !tx_valid)
    else $error("high word write sent");
  a_low_send: assert property (low_wr && !ext_mode &&
    wtype == `LITU_DT_FIXED && wvec > `LITU_VEC_MAX
    |=> tx_valid && tx_vector == $past(wvec))
    else $error("low word write did not send");
  a_sill_hold: assert property (!tx_valid && low_wr &&
    wtype == `LITU_DT_FIXED && wvec <= `LITU_VEC_MAX |=> !tx_valid)
    else $error("illegal vector sent");
  a_redir_hold: assert property (!tx_valid && low_wr && ext_mode &&
    wtype == `LITU_DT_LOWEST |=> !tx_valid)
    else $error("lowest priority sent");
  a_status_holds: assert property (tx_valid && !tx_accept &&
    !tx_fail && !mreg_wr |=> tx_valid)
    else $error("status cleared before accept");
  a_accept_logs: assert property (core_offer_valid && core_accept
    |=> !core_offer_valid && pending_request[$past(core_offer_vector)])
    else $error("accepted offer not pending");
  a_refuse_retry: assert property (core_offer_valid && core_refuse
    |=> !core_offer_valid ##[1:4] core_offer_valid)
    else $error("refused offer not retried");
  a_startup_drop: assert property (tx_valid && tx_fail && !mreg_wr &&
    tx_type == `LITU_DT_START |=> !tx_valid)
    else $error("start-up retried");
  a_deassert_all: assert property (tx_valid &&
    tx_type == `LITU_DT_INIT && !tx_level && tx_trigger
    |-> tx_shorthand == `LITU_SH_ALL)
    else $error("de-assert not broadcast");
  c_refuse: cover property (core_refuse);
  c_fault: cover property (mreg_fault);
  c_fail: cover property (tx_valid && tx_fail);
endmodule // litu_chk
bind litu_top litu_chk CHK (.clock, .reset, .ext_mode, .mreg_rd, .mreg_wr,
  .mreg_addr, .mreg_wdata, .mreg_fault, .core_offer_valid,
  .core_offer_vector, .core_accept, .core_refuse, .pending_request,
  .tx_valid, .tx_vector, .tx_type, .tx_level, .tx_trigger, .tx_shorthand,
  .tx_accept, .tx_fail);
`default_nettype wire

//--- verification/litu_partner.sv
`default_nettype none
module litu_partner (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic slow,
  input  wire logic refuse_more,
  input  wire logic fail_more,
  input  wire logic offer_valid,
  input  wire logic tx_valid,
  output var  logic core_accept,
  output var  logic core_refuse,
  output var  logic tx_accept,
  output var  logic tx_fail
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // Core and remote units
  // ----
  int oc, tc;
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      {core_accept, core_refuse, tx_accept, tx_fail} <= 4'h0;
      oc <= 0;
      tc <= 0;
    end else begin
      {core_accept, core_refuse, tx_accept, tx_fail} <= 4'h0;
      // Never answer twice: the pulse guard keeps one answer per offer
      if (offer_valid && !core_accept && !core_refuse) begin
        oc <= (oc >= (slow ? 3 : 0)) ? 0 : oc + 1;
        if (oc >= (slow ? 3 : 0)) begin
          core_refuse <= refuse_more;
          core_accept <= !refuse_more;
        end
      end
      if (tx_valid && !tx_accept && !tx_fail) begin
        tc <= (tc >= (slow ? 3 : 0)) ? 0 : tc + 1;
        if (tc >= (slow ? 3 : 0)) begin
          tx_fail   <= fail_more;
          tx_accept <= !fail_more;
        end
      end
    end
  end
endmodule // litu_partner
`default_nettype wire

//--- verification/litu_top_test.sv
`include "litu_defines.vh"
`default_nettype none
module litu_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic         clock = 0, reset = 1, ext = 0, rdq = 0, wrq = 0;
  logic         rxv = 0, eoi = 0, slow = 0, ref_m = 0, fail_m = 0;
  logic [7:0]   addr = '0, rxvec = '0, eoi_vec = '0, ovec, txvec, tdst;
  logic [31:0]  wdat = '0, rdat;
  logic         flt, rxr, ov, acc, rfs, txv, tdm, tlv, ttr, tac, tfl;
  logic [2:0]   ttyp;
  logic [1:0]   tsh;
  logic [255:0] pend, exp_pend = '0;
  int           miscompares = 0, tests_run = 0, cyc = 0;
  litu_top #(.DIV_W(3)) DUT (.clock(clock), .reset(reset), .ext_mode(ext),
    .mreg_rd(rdq), .mreg_wr(wrq), .mreg_addr(addr), .mreg_wdata(wdat),
    .mreg_rdata(rdat), .mreg_fault(flt), .rx_valid(rxv), .rx_vector(rxvec),
    .rx_ready(rxr), .core_offer_valid(ov), .core_offer_vector(ovec),
    .core_accept(acc), .core_refuse(rfs), .core_eoi_valid(eoi),
    .core_eoi_vector(eoi_vec), .pending_request(pend), .tx_valid(txv),
    .tx_vector(txvec), .tx_type(ttyp), .tx_dest_mode(tdm), .tx_level(tlv),
    .tx_trigger(ttr), .tx_shorthand(tsh), .tx_dest(tdst), .tx_accept(tac),
    .tx_fail(tfl));
  litu_partner PTR (.clock(clock), .reset(reset), .slow(slow),
    .refuse_more(ref_m), .fail_more(fail_m), .offer_valid(ov),
    .tx_valid(txv), .core_accept(acc), .core_refuse(rfs), .tx_accept(tac),
    .tx_fail(tfl));
  always #2 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    // Whole run needs a few hundred cycles; hang guard well above it
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ----
  // Bus and check tasks
  // ----
  task automatic chk(input logic [263:0] g, e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %0h exp %0h", $time, g, e);
    end
  endtask
  // Strobes stay up between back-to-back requests; tick drops them
  task automatic tick(input int n);
    wrq = 0;
    rdq = 0;
    repeat (n) @(posedge clock) #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr = a;
    wdat = d;
    rdq = 0;
    wrq = 1;
    @(posedge clock) #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr = a;
    wrq = 0;
    rdq = 1;
    @(posedge clock) #1;
    d = rdat;
  endtask
  task automatic wp(input logic [7:0] v);
    repeat (400) if (pend[v] !== 1'b1) tick(1);
  endtask
  task automatic rx(input logic [7:0] v);
    while (rxr !== 1'b1) tick(1);
    rxv = 1;
    rxvec = v;
    tick(1);
    rxv = 0;
    rxvec = ~v;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial begin
    logic [31:0] d, lw;
    int n, c0;
    logic [7:0] v, dst;
    logic [1:0] sh;
    logic dm;
    void'($urandom(81935));
    tick(10);
    reset = 0;
    chk({rxr, txv, pend}, {1'b1, 257'h0});
    rd(`LITU_A_TVEC, d);
    chk(d, 32'h10000);
    $display("reset done");
    wr(`LITU_A_EVEC, 32'h70);
    n = $urandom_range(0, 3);
    wr(`LITU_A_DIV, n);
    wr(`LITU_A_TVEC, 32'h50);
    wr(`LITU_A_ICNT, 32'd6);
    c0 = cyc;
    rd(`LITU_A_CCNT, d);
    chk(d >= 4 && d <= 6, 1);
    wp(8'h50);
    exp_pend[8'h50] = 1;
    chk(cyc - c0 >= (6 << n) && cyc - c0 <= (6 << n) + 8, 1);
    rd(`LITU_A_CCNT, d);
    chk(d, 0);
    wr(`LITU_A_DIV, 0);
    wr(`LITU_A_TVEC, 32'h20060);
    wr(`LITU_A_ICNT, 32'd1000);
    wr(`LITU_A_ICNT, 32'd3);
    wp(8'h60);
    exp_pend[8'h60] = 1;
    rd(`LITU_A_CCNT, d);
    chk(d >= 1 && d <= 3, 1);
    wr(`LITU_A_ICNT, 0);
    rd(`LITU_A_CCNT, d);
    chk(d, 0);
    wr(`LITU_A_TVEC, 32'h10061);
    wr(`LITU_A_ICNT, 32'd2);
    tick(30);
    chk(pend, exp_pend);
    $display("timer done");
    for (int i = 0; i < 4; i++) begin
      v = 8'h80 + i * 16 + $urandom_range(0, 15);
      ref_m = (i == 0);
      slow = i[0];
      rx(v);
      tick(1);
      chk({ov, ovec}, {1'b1, v});
      tick(7);
      chk(pend[v], !ref_m);
      ref_m = 0;
      wp(v);
      exp_pend[v] = 1;
    end
    rx(8'h05);
    wp(8'h70);
    exp_pend[8'h70] = 1;
    rd(`LITU_A_ERR, d);
    chk(d[6:4], 3'b100);
    chk(pend, exp_pend);
    wr(`LITU_A_ERR, 32'h1);
    $display("receive done");
    slow = 1;
    for (int t = 0; t < 7; t++) begin
      v = (t == 2 || t == 5) ? 8'h0 : $urandom_range(16, 255);
      dst = $urandom_range(0, 255);
      sh = $urandom_range(0, 3);
      dm = $urandom_range(0, 1);
      wr(`LITU_A_ICRH, {dst, 24'h0});
      chk(txv, 0);
      lw = {12'h0, sh, 2'b0, t == 5, t != 5, 2'b0, dm, t[2:0], v};
      wr(`LITU_A_ICRL, lw);
      if (t == 3) chk(txv, 0);
      else begin
        chk({txv, t == 4 ? 8'h0 : txvec, ttyp, tdm, tlv, ttr, tdst},
          {1'b1, t == 4 ? 8'h0 : v, t[2:0], dm, t != 5, t == 5, dst});
        chk(tsh, t == 5 ? 2'h2 : sh);
        rd(`LITU_A_ICRL, d);
        chk({d[31:13], d[11:0]}, {lw[31:13], lw[11:0]});
        chk(d[12], 1);
        while (txv) tick(1);
      end
    end
    rd(`LITU_A_ICRL, d);
    chk(d[12], 0);
    fail_m = 1;
    wr(`LITU_A_ICRL, 32'h699);
    tick(10);
    chk(txv, 0);
    wr(`LITU_A_ICRL, 32'h42);
    tick(10);
    chk(txv, 1);
    fail_m = 0;
    while (txv) tick(1);
    $display("send done");
    wr(`LITU_A_ICRL, 32'h05);
    rd(`LITU_A_ERR, d);
    chk({txv, d[6:4]}, 4'b0010);
    ext = 1;
    wr(`LITU_A_ERR, 0);
    wr(`LITU_A_ICRL, 32'h105);
    rd(`LITU_A_ERR, d);
    chk({txv, d[6:4]}, 4'b0001);
    wr(`LITU_A_ERR, 0);
    wr(`LITU_A_SELF, 32'h03);
    rd(`LITU_A_ERR, d);
    chk({flt, d[6:4]}, 4'b0010);
    wr(`LITU_A_ERR, 32'h1);
    chk(flt, 1);
    rd(8'h50, d);
    chk(flt, 1);
    ext = 0;
    rd(8'h50, d);
    chk({flt, d}, 0);
    eoi = 1;
    eoi_vec = 8'h50;
    tick(1);
    eoi = 0;
    tick(1);
    exp_pend[8'h50] = 0;
    chk(pend, exp_pend);
    $display("errors done");
    give_verdict();
  end
endmodule // litu_top_test
`default_nettype wire
